/* design/txl_pkg.sv */
// Shared constants and types for the transmit line clock and rail stage
package txl_pkg;

    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h4;
    localparam logic [ADDR_W-1:0] REG_INT_STAT = 4'h8;
    localparam logic [ADDR_W-1:0] REG_INT_MASK = 4'hC;

    // Control field positions
    localparam int CTRL_SINGLE_RAIL = 0;
    localparam int CTRL_LINE_CLK_EN = 1;
    localparam int CTRL_HIGH_RATE   = 2;
    localparam int CTRL_W           = 3;

    // Status field positions
    localparam int STAT_LOSS     = 0;
    localparam int STAT_DS1      = 1;
    localparam int STAT_RECOVER  = 2;
    localparam int STAT_W        = 3;

    // Interrupt field positions
    localparam int IRQ_LOSS_SET = 0;
    localparam int IRQ_LOSS_CLR = 1;
    localparam int IRQ_W        = 2;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h2;
    localparam logic [IRQ_W-1:0]  MASK_RESET = 2'h0;
    localparam logic              DS1_RESET  = 1'b1;

    // Reference clock rates in kHz, low and high per standard
    localparam int DS1_LOW_KHZ   = 1544;
    localparam int DS1_HIGH_KHZ  = 6176;
    localparam int CEPT_LOW_KHZ  = 2048;
    localparam int CEPT_HIGH_KHZ = 8192;
    // High rate divides down to the line rate
    localparam int HIGH_RATE_RATIO = DS1_HIGH_KHZ / DS1_LOW_KHZ;
    localparam int DIV_W           = $clog2(HIGH_RATE_RATIO);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HIGH_RATE_RATIO - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(HIGH_RATE_RATIO / 2 - 1);

    // Timing
    localparam int CLK_MHZ             = 40;
    localparam int LOSS_WINDOW_US      = 250;
    localparam int LOSS_WIN_CYCLES_DEF = LOSS_WINDOW_US * CLK_MHZ;

    // Cycles after reset release before the strap is caught
    localparam int              INIT_W    = 2;
    localparam logic [INIT_W-1:0] INIT_DONE = 2'h3;

    typedef struct packed {
        logic ref_high_rate;
        logic line_clk_en;
        logic single_rail;
    } ctrl_t;

    typedef struct packed {
        logic pos;
        logic neg;
    } rails_t;

    typedef enum logic [1:0] {
        MON_OK,
        MON_LOST,
        MON_RECOVER
    } mon_state_t;

endpackage

/* design/pin_sync.sv */
// Two-stage synchroniser with edge detection for one pin
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Asynchronous pin
    input  wire logic pin_i,
    // Synchronised level and edge pulses
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o  = sync_q & ~prev_q;
    assign fall_o  = ~sync_q & prev_q;
endmodule

/* design/window_timer.sv */
// Saturating window counter that flags a full window
`timescale 1ns/1ps
module window_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Control
    input  wire logic         clear_i,
    input  wire logic [W-1:0] limit_i,
    // Window elapsed, level while saturated
    output logic              done_o
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else if (clear_i) begin
            cnt_q <= '0;
        end else if (cnt_q != limit_i) begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    assign done_o = (cnt_q == limit_i) & ~clear_i;
endmodule

/* design/tx_line_clock_and_rail_output.sv */
// Transmit line clock, reference loss monitor and rail output stage
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
// What this block does
// - DS1 reference runs at 1.544 or 6.176 MHz; both accepted.
// - CEPT reference runs at 2.048 or 8.192 MHz; both accepted.
// - Loss flag rises after 250 us without a reference edge.
// - Loss flag falls 250 us after the first edge on resumption.
// - Optional line clock output at the line rate.
// - Positive rail carries positive data, changes on line clock rise.
// - Negative rail carries negative data, changes on line clock rise.
// - Single rail puts the whole data stream on the positive rail.
// - Single rail holds the negative rail at zero.
// - After reset the mode comes from the line standard strap.
// - Strap high selects DS1, strap low selects CEPT.
module tx_line_clock_and_rail_output #(
    parameter int LOSS_WIN_CYCLES = txl_pkg::LOSS_WIN_CYCLES_DEF,
    parameter int TIMER_W         = 16
) (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    // Pins from outside the clock domain
    input  wire logic                         tx_framer_ref_clock_i,
    input  wire logic                         line_standard_strap_i,
    // Framer NRZ data, same clock
    input  wire txl_pkg::rails_t              tx_data_i,
    // Register port
    input  wire logic [txl_pkg::ADDR_W-1:0]   addr_i,
    input  wire logic [txl_pkg::DATA_W-1:0]   wdata_i,
    input  wire logic                         wr_i,
    input  wire logic                         rd_i,
    output logic      [txl_pkg::DATA_W-1:0]   rdata_o,
    // Line side
    output logic                              tx_line_clock_out_o,
    output logic                              tx_pos_rail_o,
    output logic                              tx_neg_rail_o,
    output logic                              line_bit_taken_o,
    // Status
    output logic                              ref_clock_loss_flag_o,
    output logic                              line_standard_ds1_o,
    output logic                              irq_o
);
    import txl_pkg::*;

    localparam logic [TIMER_W-1:0] WIN_LIMIT = TIMER_W'(LOSS_WIN_CYCLES - 1);

    logic              ref_level;
    logic              ref_rise;
    logic              ref_fall;
    logic              ref_edge;
    logic              strap_level;
    logic              idle_done;
    logic              rec_done;
    logic              line_rise;
    logic              line_fall;
    ctrl_t             ctrl_q;
    mon_state_t        mon_q;
    logic              loss_q;
    logic [DIV_W-1:0]  div_q;
    logic              lclk_q;
    rails_t            rails_q;
    logic              taken_q;
    logic [INIT_W-1:0] init_q;
    logic              mode_valid_q;
    logic              ds1_q;
    logic [IRQ_W-1:0]  int_stat_q;
    logic [IRQ_W-1:0]  int_stat_d;
    logic [IRQ_W-1:0]  int_mask_q;
    logic [IRQ_W-1:0]  events;
    logic              irq_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              wr_ctrl;
    logic              wr_int_stat;
    logic              wr_int_mask;

    // The reference is sampled, not used as a clock: no second domain
    pin_sync ref_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (tx_framer_ref_clock_i),
        .level_o (ref_level),
        .rise_o  (ref_rise),
        .fall_o  (ref_fall)
    );

    pin_sync strap_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (line_standard_strap_i),
        .level_o (strap_level),
        .rise_o  (),
        .fall_o  ()
    );

    assign ref_edge = ref_rise | ref_fall;

    // Idle window restarts on every reference edge
    window_timer #(
        .W (TIMER_W)
    ) idle_timer (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .clear_i (ref_edge),
        .limit_i (WIN_LIMIT),
        .done_o  (idle_done)
    );

    // Recovery window runs only while recovering
    window_timer #(
        .W (TIMER_W)
    ) rec_timer (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .clear_i (mon_q != MON_RECOVER),
        .limit_i (WIN_LIMIT),
        .done_o  (rec_done)
    );

    // Loss monitor
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mon_q  <= MON_OK;
            loss_q <= 1'b0;
        end else begin
            unique case (mon_q)
                MON_OK: begin
                    if (idle_done) begin
                        mon_q  <= MON_LOST;
                        loss_q <= 1'b1;
                    end
                end
                MON_LOST: begin
                    if (ref_edge) begin
                        mon_q <= MON_RECOVER;
                    end
                end
                MON_RECOVER: begin
                    if (rec_done) begin
                        mon_q  <= MON_OK;
                        loss_q <= 1'b0;
                    end else if (idle_done) begin
                        mon_q <= MON_LOST;
                    end
                end
            endcase
        end
    end

    // Line clock: high rate reference is divided down to the line rate
    assign line_rise = ctrl_q.ref_high_rate ?
                       (ref_rise && div_q == DIV_LAST) : ref_rise;
    assign line_fall = ctrl_q.ref_high_rate ?
                       (ref_rise && div_q == DIV_HALF) : ref_fall;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= '0;
        end else if (!ctrl_q.ref_high_rate) begin
            div_q <= '0;
        end else if (ref_rise) begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    // Held low when disabled; rail timing keeps running regardless
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lclk_q <= 1'b0;
        end else if (!ctrl_q.line_clk_en) begin
            lclk_q <= 1'b0;
        end else if (line_rise) begin
            lclk_q <= 1'b1;
        end else if (line_fall) begin
            lclk_q <= 1'b0;
        end
    end

    // Rails change together with the line clock rise
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rails_q <= '0;
            taken_q <= 1'b0;
        end else begin
            taken_q <= line_rise;
            if (line_rise) begin
                rails_q.pos <= tx_data_i.pos;
                if (ctrl_q.single_rail) begin
                    rails_q.neg <= 1'b0;
                end else begin
                    rails_q.neg <= tx_data_i.neg;
                end
            end
        end
    end

    // Strap caught once the synchroniser holds a settled value
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_q       <= '0;
            mode_valid_q <= 1'b0;
            ds1_q        <= DS1_RESET;
        end else if (!mode_valid_q) begin
            if (init_q == INIT_DONE) begin
                mode_valid_q <= 1'b1;
                ds1_q        <= strap_level;
            end else begin
                init_q <= init_q + INIT_W'(1);
            end
        end
    end

    // Register port
    assign wr_ctrl     = wr_i && addr_i == REG_CTRL;
    assign wr_int_stat = wr_i && addr_i == REG_INT_STAT;
    assign wr_int_mask = wr_i && addr_i == REG_INT_MASK;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= ctrl_t'(wdata_i[CTRL_W-1:0]);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_mask_q <= MASK_RESET;
        end else if (wr_int_mask) begin
            int_mask_q <= wdata_i[IRQ_W-1:0];
        end
    end

    always_comb begin
        events                = '0;
        events[IRQ_LOSS_SET]  = mon_q == MON_OK && idle_done;
        events[IRQ_LOSS_CLR]  = mon_q == MON_RECOVER && rec_done;
        int_stat_d            = int_stat_q;
        if (wr_int_stat) begin
            int_stat_d = int_stat_q & ~wdata_i[IRQ_W-1:0];
        end
        // A new event beats a clear in the same cycle
        int_stat_d = int_stat_d | events;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_stat_q <= '0;
            irq_q      <= 1'b0;
        end else begin
            int_stat_q <= int_stat_d;
            irq_q      <= |(int_stat_d & int_mask_q);
        end
    end

    always_comb begin
        rdata_d = '0;
        unique case (addr_i)
            REG_CTRL: begin
                rdata_d[CTRL_W-1:0] = ctrl_q;
            end
            REG_STATUS: begin
                rdata_d[STAT_LOSS]    = loss_q;
                rdata_d[STAT_DS1]     = ds1_q;
                rdata_d[STAT_RECOVER] = mon_q == MON_RECOVER;
            end
            REG_INT_STAT: begin
                rdata_d[IRQ_W-1:0] = int_stat_q;
            end
            REG_INT_MASK: begin
                rdata_d[IRQ_W-1:0] = int_mask_q;
            end
            default: begin
                rdata_d = '0;
            end
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else if (rd_i) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end

    assign rdata_o               = rdata_q;
    assign tx_line_clock_out_o   = lclk_q;
    assign tx_pos_rail_o         = rails_q.pos;
    assign tx_neg_rail_o         = rails_q.neg;
    assign line_bit_taken_o      = taken_q;
    assign ref_clock_loss_flag_o = loss_q;
    assign line_standard_ds1_o   = ds1_q;
    assign irq_o                 = irq_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_pos_rail_update: assert property (
        line_rise |=> tx_pos_rail_o == $past(tx_data_i.pos))
        else $error("positive rail not loaded on line clock rise");

    a_rails_hold: assert property (
        !line_rise |=> $stable(tx_pos_rail_o) && $stable(tx_neg_rail_o))
        else $error("rail changed away from line clock rise");

    a_neg_dual_rail: assert property (
        line_rise && !ctrl_q.single_rail
        |=> tx_neg_rail_o == $past(tx_data_i.neg))
        else $error("negative rail not loaded in dual rail");

    a_neg_single_zero: assert property (
        line_rise && ctrl_q.single_rail |=> !tx_neg_rail_o)
        else $error("negative rail not zero in single rail");

    a_lclk_with_data: assert property (
        $rose(tx_line_clock_out_o) |-> $past(line_rise) && line_bit_taken_o)
        else $error("line clock rose without a data update");

    a_loss_quiet: assert property (
        $rose(ref_clock_loss_flag_o)
        |-> !$past(ref_edge, 1) && !$past(ref_edge, 2))
        else $error("loss flag rose right after a reference edge");

    a_loss_release: assert property (
        $fell(ref_clock_loss_flag_o) |-> $past(mon_q) == MON_RECOVER
        && $past(rec_done))
        else $error("loss flag fell without a full recovery window");

    a_loss_enter_rec: assert property (
        mon_q == MON_LOST && ref_edge |=> mon_q == MON_RECOVER
        && ref_clock_loss_flag_o)
        else $error("first edge did not start recovery");

    a_strap_mode: assert property (
        $rose(mode_valid_q) |-> line_standard_ds1_o == $past(strap_level))
        else $error("mode does not match strap");

    a_irq_loss: assert property (
        $rose(ref_clock_loss_flag_o) && int_mask_q[IRQ_LOSS_SET]
        |-> ##[0:1] irq_o)
        else $error("masked-in loss event gave no interrupt");

    c_loss_seen: cover property ($rose(ref_clock_loss_flag_o));
    c_loss_clear: cover property ($fell(ref_clock_loss_flag_o));
    c_single_rise: cover property (line_rise && ctrl_q.single_rail);
    c_high_rate: cover property (line_rise && ctrl_q.ref_high_rate);
endmodule

/* test/liu_model.sv */
// Reference clock source and line receiver at the block's line side
`timescale 1ns/1ps
module liu_model #(
    parameter real HALF_NS = 100.0
) (
    // Bench control
    input  wire logic run_i,
    // Line side of the block
    input  wire logic line_clk_i,
    input  wire logic pos_i,
    input  wire logic neg_i,
    // Reference clock to the block
    output logic      ref_clk_o,
    // Last captured line bit
    output logic      pos_o,
    output logic      neg_o,
    output int        bits_o
);
    int n_bits = 0;

    assign bits_o = n_bits;

    // Odd offset keeps edges apart from the system clock
    initial begin
        ref_clk_o = 1'b0;
        #3.1;
        forever begin
            #(HALF_NS);
            if (run_i) begin
                ref_clk_o = ~ref_clk_o;
            end
        end
    end

    // Sample mid-bit, away from the rise where rails change
    always @(negedge line_clk_i) begin
        pos_o  <= pos_i;
        neg_o  <= neg_i;
        n_bits <= n_bits + 1;
    end
endmodule

/* test/tx_line_clock_and_rail_output_tb_top.sv */
// Self-checking bench for the transmit line clock and rail stage
`timescale 1ns/1ps
module tx_line_clock_and_rail_output_tb_top;
    import txl_pkg::*;
    localparam int WIN = 64;
    logic              clk_i;
    logic              rst_n_i;
    logic              strap;
    logic              ref_run;
    logic              ref_clk;
    rails_t            tx_data;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic              line_clk;
    logic              pos;
    logic              neg;
    logic              taken;
    logic              loss;
    logic              ds1;
    logic              irq;
    logic              lp;
    logic              ln;
    int                lbits;
    int                err_count = 0;
    int                n_compared = 0;
    int                seed = 24;
    int                cyc = 0;
    int                ctrl_m;
    int                mask_m;
    rails_t            last_e;
    rails_t            exp_q[$];

    tx_line_clock_and_rail_output #(
        .LOSS_WIN_CYCLES (WIN)
    ) u_tx_line_clock_and_rail_output (
        .clk_i                 (clk_i),
        .rst_n_i               (rst_n_i),
        .tx_framer_ref_clock_i (ref_clk),
        .line_standard_strap_i (strap),
        .tx_data_i             (tx_data),
        .addr_i                (addr),
        .wdata_i               (wdata),
        .wr_i                  (wr),
        .rd_i                  (rd),
        .rdata_o               (rdata),
        .tx_line_clock_out_o   (line_clk),
        .tx_pos_rail_o         (pos),
        .tx_neg_rail_o         (neg),
        .line_bit_taken_o      (taken),
        .ref_clock_loss_flag_o (loss),
        .line_standard_ds1_o   (ds1),
        .irq_o                 (irq)
    );

    liu_model u_liu_model (
        .run_i      (ref_run),
        .line_clk_i (line_clk),
        .pos_i      (pos),
        .neg_i      (neg),
        .ref_clk_o  (ref_clk),
        .pos_o      (lp),
        .neg_o      (ln),
        .bits_o     (lbits)
    );

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) cyc <= cyc + 1;

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_compared++;
        if (seen !== expv) begin
            err_count++;
            $display("CHECK FAILED at %0t seen %0h expected %0h",
                     $time, seen, expv);
        end
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr    <= 1'b0;
        if (a == REG_CTRL) ctrl_m = d & 8'h07;
        if (a == REG_INT_MASK) mask_m = d & 8'h03;
    endtask

    task automatic reg_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd   <= 1'b0;
        @(negedge clk_i);
        check(rdata, e);
    endtask

    task automatic do_reset(input logic s);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        strap   <= s;
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        check({pos, neg, loss, irq, line_clk, rdata, ds1}, 14'h0001);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        ctrl_m = CTRL_RESET;
        mask_m = MASK_RESET;
        repeat (8) @(negedge clk_i);
        check(ds1, s);
    endtask

    task automatic wait_taken;
        int i;
        i = 0;
        do begin
            @(negedge clk_i);
            i++;
        end while (taken !== 1'b1 && i < 300);
        check(taken, 1'b1);
    endtask

    // Data changes only just after a bit is taken, never near a sample
    task automatic next_data;
        logic [31:0] r;
        rails_t      d;
        r = $random(seed);
        d = r[1:0];
        @(posedge clk_i);
        tx_data <= d;
        if (ctrl_m[CTRL_SINGLE_RAIL]) d.neg = 1'b0;
        exp_q.push_back(d);
    endtask

    task automatic run_bits(input int n);
        exp_q.delete();
        wait_taken();
        next_data();
        repeat (n) begin
            wait_taken();
            last_e = exp_q.pop_front();
            check({pos, neg}, last_e);
            check(line_clk, ctrl_m[CTRL_LINE_CLK_EN]);
            next_data();
        end
    endtask

    task automatic count_bits(output int nb, output int nh);
        nb = 0;
        nh = 0;
        repeat (320) begin
            @(negedge clk_i);
            if (taken === 1'b1) nb++;
            if (line_clk === 1'b1) nh++;
        end
    endtask

    task automatic wait_loss(input logic v, output int at);
        int i;
        i = 0;
        while (loss !== v && i < 200) begin
            @(negedge clk_i);
            i++;
        end
        at = cyc;
    endtask

    initial begin
        int nb;
        int nh;
        int t0;
        int t1;
        int rates[3] = '{2, 6, 0};
        int lo[3] = '{39, 9, 39};
        rst_n_i = 1'b0;
        strap   = 1'b1;
        ref_run = 1'b1;
        tx_data = '0;
        addr    = '0;
        wdata   = '0;
        wr      = 1'b0;
        rd      = 1'b0;
        do_reset(1'b1);
        reg_chk(REG_CTRL, CTRL_RESET);
        reg_chk(REG_INT_MASK, MASK_RESET);
        reg_chk(REG_STATUS, 8'h02);
        reg_wr(REG_INT_MASK, 8'hFF);
        reg_chk(REG_INT_MASK, 8'h03);
        reg_wr(4'h6, 8'hFF);
        reg_chk(4'h6, 8'h00);
        reg_chk(REG_CTRL, CTRL_RESET);
        for (int k = 0; k < 3; k++) begin
            reg_wr(REG_CTRL, 8'(k));
            run_bits(k == 2 ? 4 : 12);
        end
        reg_wr(REG_CTRL, 8'h02);
        t0 = lbits;
        run_bits(10);
        // Past the line clock fall, before the next bit reaches the far side
        repeat (6) @(negedge clk_i);
        check(lbits - t0 >= 10, 1'b1);
        check({lp, ln}, last_e);
        for (int k = 0; k < 3; k++) begin
            reg_wr(REG_CTRL, 8'(rates[k]));
            repeat (40) @(negedge clk_i);
            count_bits(nb, nh);
            check(nb >= lo[k] && nb <= lo[k] + 2, 1'b1);
            check(nh == 0, k == 2);
        end
        // Loss, masked then unmasked interrupt, and recovery
        reg_wr(REG_INT_MASK, 8'h00);
        reg_wr(REG_INT_STAT, 8'h03);
        @(posedge clk_i);
        ref_run <= 1'b0;
        t0 = cyc;
        wait_loss(1'b1, t1);
        check(t1 - t0 >= 56 && t1 - t0 <= 74, 1'b1);
        reg_chk(REG_INT_STAT, 8'h01);
        check(irq, 1'b0);
        reg_chk(REG_STATUS, 8'h03);
        reg_wr(REG_INT_MASK, 8'h01);
        repeat (3) @(negedge clk_i);
        check(irq, 1'b1);
        reg_wr(REG_INT_STAT, 8'h01);
        repeat (3) @(negedge clk_i);
        check(irq, 1'b0);
        @(posedge clk_i);
        ref_run <= 1'b1;
        t0 = cyc;
        repeat (20) @(negedge clk_i);
        check(loss, 1'b1);
        reg_chk(REG_STATUS, 8'h07);
        wait_loss(1'b0, t1);
        check(t1 - t0 >= 60 && t1 - t0 <= 77, 1'b1);
        reg_chk(REG_INT_STAT, 8'h02);
        reg_wr(REG_INT_MASK, 8'h03);
        repeat (3) @(negedge clk_i);
        check(irq, 1'b1);
        reg_wr(REG_INT_STAT, 8'h02);
        repeat (3) @(negedge clk_i);
        check(irq, 1'b0);
        do_reset(1'b0);
        reg_chk(REG_STATUS, 8'h00);
        test_done();
    end

    initial begin
        #500000;
        err_count++;
        test_done();
    end
endmodule
